// ==== verilog/bct_pkg.sv ====
// Register indices, field positions, reset values and timing constants.
package bct_pkg;
   // Register index; the byte address on the bus is four times the index.
   localparam logic [15:0] IDX_STEP6 = 16'h407e;
   localparam logic [15:0] IDX_STEP7 = 16'h4080;
   localparam logic [15:0] IDX_BCNT = 16'h4082;
   localparam logic [15:0] IDX_BCAP = 16'h4084;
   localparam logic [15:0] IDX_BRLD = 16'h4086;
   localparam logic [15:0] IDX_RLIM = 16'h4088;
   localparam logic [15:0] IDX_RCNT = 16'h408a;
   localparam logic [15:0] IDX_UACT = 16'h408c;
   localparam logic [15:0] IDX_UFLT = 16'h408e;
   localparam logic [15:0] IDX_URES = 16'h4090;
   localparam logic [15:0] IDX_UIGN = 16'h4092;
   localparam logic [15:0] IDX_KFALL = 16'h4094;
   localparam logic [15:0] IDX_KRISE = 16'h4096;
   localparam logic [15:0] IDX_IBUS = 16'h4098;
   localparam logic [15:0] IDX_MASKANG = 16'h40a0;
   localparam logic [15:0] IDX_COMMANG = 16'h40a2;
   localparam logic [15:0] IDX_CTRL = 16'h40a4;
   localparam logic [15:0] IDX_ISTAT = 16'h40a6;
   localparam logic [15:0] IDX_IMASK = 16'h40a8;
   localparam int ADDR_W = 18;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_BCNT = 16'h8000;
   localparam logic [15:0] RST_RCNT = 16'hffff;
   localparam logic [15:0] PAT_MASK = 16'h7fff;
   localparam logic [15:0] POS15_MASK = 16'h7fff;
   localparam int F_EDGE_DIR = 14;
   localparam int F_EDGE_SEL = 12;
   localparam int F_POL = 6;
   localparam int F_EN = 0;
   localparam int C_BASE_EN = 0;
   localparam int C_RLD_EN = 1;
   localparam int C_BRS_POS = 2;
   localparam int C_BRS_WTIM = 3;
   localparam int C_STEP = 4;
   localparam int C_WSEQ = 5;
   localparam int I_POS = 0;
   localparam int I_BOVF = 1;
   localparam int I_ROVF = 2;
   localparam int I_WSEQ = 3;
   localparam int CLK_MHZ = 200;
   localparam int DEAD_NS = 500;
   localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] CH_ACT = 4'h0;
   localparam logic [3:0] CH_FLT = 4'h1;
   localparam logic [3:0] CH_IBUS = 4'h4;
   localparam int FILT_SHIFT = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verilog/bct_commutation_timer.sv ====
// Commutation timer for a brushless motor with an AXI4-Lite register port.
`timescale 1ns/10ps
module bct_commutation_timer #(
   parameter logic [15:0] DEAD_CYC = 16'(bct_pkg::DEAD_CYC),
   parameter logic [3:0] ACT_CH = bct_pkg::CH_ACT,
   parameter logic [3:0] FLT_CH = bct_pkg::CH_FLT,
   parameter logic [3:0] IBUS_CH = bct_pkg::CH_IBUS,
   parameter int FILT_SHIFT = bct_pkg::FILT_SHIFT
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [bct_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [bct_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [2:0] cmpIn,
   input wire logic pwmIn,
   input wire logic adcValid,
   input wire logic [3:0] adcChan,
   input wire logic [11:0] adcData,
   output logic [2:0] gateHigh,
   output logic [2:0] gateLow,
   output logic irq
);

   function automatic logic isMapped(input logic [15:0] idx);
      case (idx)
         bct_pkg::IDX_STEP6, bct_pkg::IDX_STEP7, bct_pkg::IDX_BCNT,
         bct_pkg::IDX_BCAP, bct_pkg::IDX_BRLD, bct_pkg::IDX_RLIM,
         bct_pkg::IDX_RCNT, bct_pkg::IDX_UACT, bct_pkg::IDX_UFLT,
         bct_pkg::IDX_URES, bct_pkg::IDX_UIGN, bct_pkg::IDX_KFALL,
         bct_pkg::IDX_KRISE, bct_pkg::IDX_IBUS, bct_pkg::IDX_MASKANG,
         bct_pkg::IDX_COMMANG, bct_pkg::IDX_CTRL, bct_pkg::IDX_ISTAT,
         bct_pkg::IDX_IMASK: isMapped = 1'b1;
         default: isMapped = 1'b0;
      endcase
   endfunction

   function automatic logic [15:0] upd(input logic [15:0] old,
                                       input logic [15:0] d,
                                       input logic [15:0] m);
      upd = (old & ~m) | (d & m);
   endfunction

   // Bus slave state.
   logic awHeld, wHeld, next_awHeld, next_wHeld;
   logic [15:0] awIdx, next_awIdx, wData, next_wData, wMask, next_wMask;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic doWrite;
   logic [15:0] rdVal;

   // Register file and timers.
   logic [15:0] step6, step7, bcnt, bcap, brld, rlim, rcnt;
   logic [15:0] uact, uflt, ures, uign, kfall, krise, ibus;
   logic [15:0] maskAng, commAng;
   logic [15:0] next_step6, next_step7, next_bcnt, next_bcap, next_brld;
   logic [15:0] next_rlim, next_rcnt, next_uact, next_uflt, next_ures;
   logic [15:0] next_uign, next_kfall, next_krise, next_ibus;
   logic [15:0] next_maskAng, next_commAng;
   logic [4:0] ctrl, next_ctrl;
   logic [3:0] istat, imask, next_istat, next_imask, istatClr;
   logic next_irq;
   logic [15:0] ctlWr, imaskWr, curPat, sample16, coefSel;
   logic [31:0] prod;
   logic signed [16:0] filtDiff, filtStep;
   logic posEvt, wseqEvt, baseRst, bovf, rovf;

   // Comparator inputs and gate drive.
   logic [2:0] cmpS1, cmpS2, cmpPrev, rise, fall;
   logic [1:0] selPh;
   logic pwmPrev;
   logic [2:0] nextHigh, nextLow;

   assign doWrite = awHeld && wHeld && !bvalid;

   always_comb begin
      next_awHeld = awHeld;
      next_wHeld = wHeld;
      next_awIdx = awIdx;
      next_wData = wData;
      next_wMask = wMask;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (awvalid && awready) begin
         next_awHeld = 1'b1;
         next_awIdx = awaddr[17:2];
      end
      if (wvalid && wready) begin
         next_wHeld = 1'b1;
         next_wData = wdata[15:0];
         next_wMask = {{8{wstrb[1]}}, {8{wstrb[0]}}};
      end
      if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (doWrite) begin
         next_awHeld = 1'b0;
         next_wHeld = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = isMapped(awIdx) ? bct_pkg::RESP_OKAY
                                      : bct_pkg::RESP_SLVERR;
      end
      if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rdata = {16'h0000, rdVal};
         next_rresp = isMapped(araddr[17:2]) ? bct_pkg::RESP_OKAY
                                             : bct_pkg::RESP_SLVERR;
      end
      next_awready = !next_awHeld && !next_bvalid;
      next_wready = !next_wHeld && !next_bvalid;
      next_arready = !next_rvalid;
   end

   always_comb begin
      case (araddr[17:2])
         bct_pkg::IDX_STEP6: rdVal = step6;
         bct_pkg::IDX_STEP7: rdVal = step7;
         bct_pkg::IDX_BCNT: rdVal = bcnt;
         bct_pkg::IDX_BCAP: rdVal = bcap;
         bct_pkg::IDX_BRLD: rdVal = brld;
         bct_pkg::IDX_RLIM: rdVal = rlim;
         bct_pkg::IDX_RCNT: rdVal = rcnt;
         bct_pkg::IDX_UACT: rdVal = uact;
         bct_pkg::IDX_UFLT: rdVal = uflt;
         bct_pkg::IDX_URES: rdVal = ures;
         bct_pkg::IDX_UIGN: rdVal = uign;
         bct_pkg::IDX_KFALL: rdVal = kfall;
         bct_pkg::IDX_KRISE: rdVal = krise;
         bct_pkg::IDX_IBUS: rdVal = ibus;
         bct_pkg::IDX_MASKANG: rdVal = maskAng;
         bct_pkg::IDX_COMMANG: rdVal = commAng;
         bct_pkg::IDX_CTRL: rdVal = {11'h000, ctrl};
         bct_pkg::IDX_ISTAT: rdVal = {12'h000, istat};
         bct_pkg::IDX_IMASK: rdVal = {12'h000, imask};
         default: rdVal = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awIdx <= bct_pkg::RST_ZERO;
         wData <= bct_pkg::RST_ZERO;
         wMask <= bct_pkg::RST_ZERO;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= bct_pkg::RESP_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= bct_pkg::RESP_OKAY;
      end else begin
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         awIdx <= next_awIdx;
         wData <= next_wData;
         wMask <= next_wMask;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   // The comparators are asynchronous to the system clock.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmpS1 <= 3'h0;
         cmpS2 <= 3'h0;
         cmpPrev <= 3'h0;
         pwmPrev <= 1'b0;
      end else begin
         cmpS1 <= cmpIn;
         cmpS2 <= cmpS1;
         cmpPrev <= cmpS2;
         pwmPrev <= pwmIn;
      end
   end

   assign curPat = ctrl[bct_pkg::C_STEP] ? step7 : step6;
   assign selPh = curPat[bct_pkg::F_EDGE_SEL +: 2];
   assign rise = cmpS2 & ~cmpPrev;
   assign fall = ~cmpS2 & cmpPrev;
   assign ctlWr = upd({11'h000, ctrl}, wData, wMask);
   assign imaskWr = upd({12'h000, imask}, wData, wMask);
   assign wseqEvt = doWrite && awIdx == bct_pkg::IDX_CTRL
                    && ctlWr[bct_pkg::C_WSEQ];
   assign istatClr = (doWrite && awIdx == bct_pkg::IDX_ISTAT) ?
                     (wData[3:0] & wMask[3:0]) : 4'h0;
   assign baseRst = (ctrl[bct_pkg::C_BRS_POS] && posEvt)
                    || (ctrl[bct_pkg::C_BRS_WTIM] && rovf);
   assign bovf = ctrl[bct_pkg::C_BASE_EN] && !baseRst && bcnt == brld;
   assign rovf = ctrl[bct_pkg::C_RLD_EN] && rcnt == rlim;
   assign sample16 = {1'b0, adcData, 3'b000};
   assign coefSel = curPat[bct_pkg::F_EDGE_DIR] ? kfall : krise;
   assign prod = uact * coefSel;
   assign filtDiff = $signed({1'b0, sample16}) - $signed({1'b0, ibus});
   assign filtStep = filtDiff >>> FILT_SHIFT;

   always_comb begin
      posEvt = 1'b0;
      if (selPh != 2'h0) begin
         posEvt = curPat[bct_pkg::F_EDGE_DIR] ? fall[selPh - 2'h1]
                                              : rise[selPh - 2'h1];
      end
   end

   always_comb begin
      next_step6 = step6;
      next_step7 = step7;
      next_bcnt = bcnt;
      next_bcap = bcap;
      next_brld = brld;
      next_rlim = rlim;
      next_rcnt = rcnt;
      next_uact = uact;
      next_uflt = uflt;
      next_ures = ures;
      next_uign = uign;
      next_kfall = kfall;
      next_krise = krise;
      next_ibus = ibus;
      next_maskAng = maskAng;
      next_commAng = commAng;
      next_ctrl = ctrl;
      next_imask = imask;
      if (doWrite) begin
         case (awIdx)
            bct_pkg::IDX_STEP6:
               next_step6 = upd(step6, wData, wMask) & bct_pkg::PAT_MASK;
            bct_pkg::IDX_STEP7:
               next_step7 = upd(step7, wData, wMask) & bct_pkg::PAT_MASK;
            bct_pkg::IDX_BCNT: next_bcnt = upd(bcnt, wData, wMask);
            bct_pkg::IDX_BCAP: next_bcap = upd(bcap, wData, wMask);
            bct_pkg::IDX_BRLD: next_brld = upd(brld, wData, wMask);
            bct_pkg::IDX_RLIM: next_rlim = upd(rlim, wData, wMask);
            bct_pkg::IDX_RCNT: next_rcnt = upd(rcnt, wData, wMask);
            bct_pkg::IDX_UACT:
               next_uact = upd(uact, wData, wMask) & bct_pkg::POS15_MASK;
            bct_pkg::IDX_UFLT:
               next_uflt = upd(uflt, wData, wMask) & bct_pkg::POS15_MASK;
            bct_pkg::IDX_URES: next_ures = upd(ures, wData, wMask);
            bct_pkg::IDX_UIGN: next_uign = upd(uign, wData, wMask);
            bct_pkg::IDX_KFALL:
               next_kfall = upd(kfall, wData, wMask) & bct_pkg::POS15_MASK;
            bct_pkg::IDX_KRISE:
               next_krise = upd(krise, wData, wMask) & bct_pkg::POS15_MASK;
            bct_pkg::IDX_MASKANG:
               next_maskAng = upd(maskAng, wData, wMask);
            bct_pkg::IDX_COMMANG:
               next_commAng = upd(commAng, wData, wMask);
            bct_pkg::IDX_CTRL: next_ctrl = ctlWr[4:0];
            bct_pkg::IDX_IMASK: next_imask = imaskWr[3:0];
            default: next_ctrl = ctrl;
         endcase
      end
      // Hardware updates win over a software write in the same cycle.
      // Base reset and capture.
      if (baseRst) begin
         next_bcap = bcnt;
         next_bcnt = bct_pkg::RST_ZERO;
      end else if (bovf) begin
         next_bcnt = bct_pkg::RST_ZERO;
      end else if (ctrl[bct_pkg::C_BASE_EN]) begin
         next_bcnt = bcnt + 16'h0001;
      end
      if (posEvt) begin
         next_rlim = commAng;
         next_rcnt = bct_pkg::RST_ZERO;
      end else if (wseqEvt) begin
         next_rlim = maskAng;
         next_rcnt = bct_pkg::RST_ZERO;
      end else if (rovf) begin
         next_rcnt = bct_pkg::RST_ZERO;
      end else if (ctrl[bct_pkg::C_RLD_EN]) begin
         next_rcnt = rcnt + 16'h0001;
      end
      if (adcValid) begin
         if (adcChan == ACT_CH && sample16 >= uign) begin
            next_uact = sample16;
         end
         if (adcChan == FLT_CH) begin
            next_uflt = sample16;
            next_ures = sample16 - prod[30:15];
         end
         if (adcChan == IBUS_CH) begin
            next_ibus = ibus + filtStep[15:0];
         end
      end
      next_istat = (istat & ~istatClr) | {wseqEvt, rovf, bovf, posEvt};
      next_irq = |(next_istat & next_imask);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         step6 <= bct_pkg::RST_ZERO;
         step7 <= bct_pkg::RST_ZERO;
         bcnt <= bct_pkg::RST_BCNT;
         bcap <= bct_pkg::RST_ZERO;
         brld <= bct_pkg::RST_ZERO;
         rlim <= bct_pkg::RST_ZERO;
         rcnt <= bct_pkg::RST_RCNT;
         uact <= bct_pkg::RST_ZERO;
         uflt <= bct_pkg::RST_ZERO;
         ures <= bct_pkg::RST_ZERO;
         uign <= bct_pkg::RST_ZERO;
         kfall <= bct_pkg::RST_ZERO;
         krise <= bct_pkg::RST_ZERO;
         ibus <= bct_pkg::RST_ZERO;
         maskAng <= bct_pkg::RST_ZERO;
         commAng <= bct_pkg::RST_ZERO;
         ctrl <= 5'h00;
         istat <= 4'h0;
         imask <= 4'h0;
         irq <= 1'b0;
      end else begin
         step6 <= next_step6;
         step7 <= next_step7;
         bcnt <= next_bcnt;
         bcap <= next_bcap;
         brld <= next_brld;
         rlim <= next_rlim;
         rcnt <= next_rcnt;
         uact <= next_uact;
         uflt <= next_uflt;
         ures <= next_ures;
         uign <= next_uign;
         kfall <= next_kfall;
         krise <= next_krise;
         ibus <= next_ibus;
         maskAng <= next_maskAng;
         commAng <= next_commAng;
         ctrl <= next_ctrl;
         istat <= next_istat;
         imask <= next_imask;
         irq <= next_irq;
      end
   end

   // Phases in order U, V, W; low-side enable and polarity sit below high.
   for (genvar p = 0; p < 3; p++) begin : g_ph
      logic lowEn, highEn, lowPol, highPol, both, lowAct, highAct;
      logic [15:0] dead, next_dead;
      assign lowEn = curPat[bct_pkg::F_EN + 2 * p];
      assign highEn = curPat[bct_pkg::F_EN + 2 * p + 1];
      assign lowPol = curPat[bct_pkg::F_POL + 2 * p];
      assign highPol = curPat[bct_pkg::F_POL + 2 * p + 1];
      assign both = lowEn && highEn;
      always_comb begin
         next_dead = dead;
         // Dead time on each PWM edge while both sides of the pair are enabled.
         if (both && pwmIn != pwmPrev) begin
            next_dead = DEAD_CYC;
         end else if (dead != 16'h0000) begin
            next_dead = dead - 16'h0001;
         end
         highAct = both ? (pwmIn && pwmIn == pwmPrev && dead == 16'h0000)
                        : (highEn && pwmIn);
         lowAct = both ? (!pwmIn && pwmIn == pwmPrev && dead == 16'h0000)
                       : lowEn;
      end
      assign nextHigh[p] = highAct ^ highPol;
      assign nextLow[p] = lowAct ^ lowPol;
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            dead <= 16'h0000;
         end else begin
            dead <= next_dead;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gateHigh <= 3'h0;
         gateLow <= 3'h0;
      end else begin
         gateHigh <= nextHigh;
         gateLow <= nextLow;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_toggle;
      curPat[1:0] == 2'h3 && pwmIn != pwmPrev;
   endsequence
   sequence s_uIdle;
      gateHigh[0] == curPat[7] && gateLow[0] == curPat[6];
   endsequence
   property p_posIrq;
      posEvt |=> istat[bct_pkg::I_POS];
   endproperty
   property p_polIdle;
      !curPat[1] ##1 !curPat[1] && $stable(curPat[7])
         |-> gateHigh[0] == curPat[7];
   endproperty
   property p_enDrive;
      curPat[1:0] == 2'h2 && pwmIn ##1 $stable(curPat)
         |-> gateHigh[0] != curPat[7];
   endproperty
   property p_baseRun;
      ctrl[0] && !baseRst && !bovf |=> bcnt == $past(bcnt) + 16'h0001;
   endproperty
   property p_capture;
      baseRst |=> bcap == $past(bcnt) && bcnt == 16'h0000;
   endproperty
   property p_baseOvf;
      bovf |=> bcnt == 16'h0000 && istat[bct_pkg::I_BOVF];
   endproperty
   property p_rldOvf;
      rovf && !posEvt && !wseqEvt |=> rcnt == 16'h0000 && istat[2];
   endproperty
   property p_maskLoad;
      wseqEvt && !posEvt |=> rlim == $past(maskAng);
   endproperty
   property p_commLoad;
      posEvt |=> rlim == $past(commAng) && rcnt == 16'h0000;
   endproperty
   property p_ignore;
      adcValid && adcChan == ACT_CH && sample16 < uign && !doWrite
         |=> uact == $past(uact);
   endproperty
   property p_dead;
      s_toggle ##1 $stable(curPat) |=> s_uIdle;
   endproperty
   a_posIrq: assert property (p_posIrq)
      else $error("Position event did not set its flag.");
   a_polIdle: assert property (p_polIdle)
      else $error("Disabled high side not at its idle level.");
   a_enDrive: assert property (p_enDrive)
      else $error("Enabled high side did not drive.");
   a_baseRun: assert property (p_baseRun)
      else $error("Base timer did not advance.");
   a_capture: assert property (p_capture)
      else $error("Base capture or reset wrong.");
   a_baseOvf: assert property (p_baseOvf)
      else $error("Base overflow handling wrong.");
   a_rldOvf: assert property (p_rldOvf)
      else $error("Reload overflow handling wrong.");
   a_maskLoad: assert property (p_maskLoad)
      else $error("Masking angle not loaded.");
   a_commLoad: assert property (p_commLoad)
      else $error("Commutation angle not loaded.");
   a_ignore: assert property (p_ignore)
      else $error("Low active sample was not ignored.");
   a_dead: assert property (p_dead)
      else $error("U pair not idle during dead time.");

endmodule

// ==== test/bct_motor_model.sv ====
// Behavioural model of the motor phase comparators and the converter.
`timescale 1ns/10ps
module bct_motor_model (
   input wire logic ref_clk,
   output logic [2:0] cmpIn,
   output logic adcValid,
   output logic [3:0] adcChan,
   output logic [11:0] adcData
);
   initial begin
      cmpIn = 3'h0;
      adcValid = 1'b0;
      adcChan = 4'h0;
      adcData = 12'h000;
   end
   // One converter result; afterwards the bus shows the inverse, not stale.
   task automatic sample(input logic [3:0] ch, input logic [11:0] v);
      @(posedge ref_clk);
      adcValid <= 1'b1;
      adcChan <= ch;
      adcData <= v;
      @(posedge ref_clk);
      adcValid <= 1'b0;
      adcChan <= ~ch;
      adcData <= ~v;
   endtask
   // Comparators are asynchronous, so they move away from the clock edge.
   task automatic bemf(input logic [2:0] lv);
      #1.3 cmpIn = lv;
   endtask
endmodule

// ==== test/bct_commutation_timer_tb.sv ====
// Register-level testbench of the commutation timer.
`timescale 1ns/10ps
`define CHK(n,e,g) begin check_count++; if ((g) !== (e)) begin fails++; \
 $display("BAD %s exp %h got %h", n, e, g); end end
module bct_commutation_timer_tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic pwmIn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [bct_pkg::ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, irq, adcValid;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata;
   logic [2:0] cmpIn, gateHigh, gateLow;
   logic [3:0] adcChan;
   logic [11:0] adcData;
   logic [15:0] d;
   int fails = 0;
   int check_count = 0;
   always #2.5 ref_clk = ~ref_clk;
   bct_commutation_timer #(.DEAD_CYC(16'h0004)) DUT (.ref_clk, .rst_n,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .cmpIn, .pwmIn, .adcValid, .adcChan,
      .adcData, .gateHigh, .gateLow, .irq);
   bct_motor_model mdl (.ref_clk, .cmpIn, .adcValid, .adcChan, .adcData);
   task automatic wr(input logic [15:0] i, input logic [15:0] v);
      @(posedge ref_clk);
      awaddr <= {i, 2'b00};
      wdata <= {16'h0000, v};
      wstrb <= 4'h3;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] i);
      @(posedge ref_clk);
      araddr <= {i, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata[15:0];
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic rc(input logic [15:0] i, input logic [15:0] e,
                     input string n);
      rd(i);
      `CHK(n, e, d)
   endtask
   task automatic summarize;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge ref_clk);
      fails++;
      summarize();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rc(bct_pkg::IDX_BCNT, 16'h8000, "bcnt");
      rc(bct_pkg::IDX_RCNT, 16'hffff, "rcnt");
      rc(16'h4000, 16'h0000, "unmapped");
      `CHK("rresp", bct_pkg::RESP_SLVERR, r)
      wr(16'h4000, 16'h1234);
      `CHK("bresp", bct_pkg::RESP_SLVERR, r)
      wr(bct_pkg::IDX_STEP7, 16'hffff);
      rc(bct_pkg::IDX_STEP7, 16'h7fff, "step7");
      $display("end regs");
      for (int p = 0; p < 2; p++) begin
         wr(bct_pkg::IDX_STEP6, p ? 16'h0041 : 16'h0001);
         repeat (2) @(posedge ref_clk);
         `CHK("gateLow", p ? 1'b0 : 1'b1, gateLow[0])
      end
      wr(bct_pkg::IDX_STEP6, 16'h0003);
      @(posedge ref_clk) pwmIn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      `CHK("dead", 2'b00, {gateHigh[0], gateLow[0]})
      repeat (6) @(posedge ref_clk);
      `CHK("pair", 2'b10, {gateHigh[0], gateLow[0]})
      wr(bct_pkg::IDX_STEP6, 16'h0802);
      repeat (2) @(posedge ref_clk);
      `CHK("gates", 6'b101000, {gateHigh, gateLow})
      $display("end gates");
      wr(bct_pkg::IDX_COMMANG, 16'h0030);
      wr(bct_pkg::IDX_STEP6, 16'h1000);
      wr(bct_pkg::IDX_CTRL, 16'h0005);
      mdl.bemf(3'h1);
      repeat (8) @(posedge ref_clk);
      rc(bct_pkg::IDX_ISTAT, 16'h0003, "pos");
      rc(bct_pkg::IDX_RLIM, 16'h0030, "comm");
      rd(bct_pkg::IDX_BCAP);
      `CHK("capture", 8'h80, d[15:8])
      wr(bct_pkg::IDX_MASKANG, 16'h0021);
      wr(bct_pkg::IDX_CTRL, 16'h0027);
      rc(bct_pkg::IDX_RLIM, 16'h0021, "mask");
      $display("end events");
      wr(bct_pkg::IDX_BRLD, 16'h0040);
      wr(bct_pkg::IDX_BCNT, 16'h0000);
      wr(bct_pkg::IDX_ISTAT, 16'h000f);
      repeat (70) @(posedge ref_clk);
      rc(bct_pkg::IDX_ISTAT, 16'h0006, "ovf");
      `CHK("irq masked", 1'b0, irq)
      wr(bct_pkg::IDX_IMASK, 16'h0002);
      @(posedge ref_clk);
      `CHK("irq on", 1'b1, irq)
      wr(bct_pkg::IDX_CTRL, 16'h0000);
      wr(bct_pkg::IDX_ISTAT, 16'h000f);
      @(posedge ref_clk);
      `CHK("irq off", 1'b0, irq)
      $display("end timers");
      mdl.sample(bct_pkg::CH_IBUS, 12'hfff);
      rc(bct_pkg::IDX_IBUS, 16'h0fff, "ibus");
      wr(bct_pkg::IDX_IBUS, 16'h1234);
      rc(bct_pkg::IDX_IBUS, 16'h0fff, "ibus ro");
      mdl.sample(bct_pkg::CH_ACT, 12'h801);
      rc(bct_pkg::IDX_UACT, 16'h4008, "act");
      wr(bct_pkg::IDX_UIGN, 16'h7000);
      mdl.sample(bct_pkg::CH_ACT, 12'h001);
      rc(bct_pkg::IDX_UACT, 16'h4008, "ignored");
      wr(bct_pkg::IDX_KRISE, 16'h7fff);
      rc(bct_pkg::IDX_KRISE, 16'h7fff, "krise");
      mdl.sample(bct_pkg::CH_FLT, 12'hfff);
      rc(bct_pkg::IDX_UFLT, 16'h7ff8, "flt");
      rc(bct_pkg::IDX_URES, 16'h3ff1, "ures");
      $display("end samples");
      summarize();
   end
endmodule
